// ===== rtl/vsoc_defs.vh
`ifndef VSOC_DEFS_VH
`define VSOC_DEFS_VH

// Register indices; byte address is four times the index.
`define VSOC_IDX_BYP_LOW   8'h0A
`define VSOC_IDX_BYP_HIGH  8'h0B
`define VSOC_IDX_V_LOW     8'h0C
`define VSOC_IDX_V_HIGH    8'h0D
`define VSOC_IDX_U_LOW     8'h0E
`define VSOC_IDX_U_HIGH    8'h0F
`define VSOC_IDX_OUT_CTRL  8'h10
`define VSOC_IDX_BYP_FIRST 8'h11
`define VSOC_IDX_STATUS    8'h12

// Field positions inside bypass_count_high_and_flags.
`define VSOC_BIT_COUNT8    0
`define VSOC_BIT_CHROMA_S  1
`define VSOC_BIT_FLD_INV   2

// Field positions inside output_control_flags.
`define VSOC_BIT_NUMFMT    0
`define VSOC_BIT_LINE_POL  1
`define VSOC_BIT_PIX_POL   2
`define VSOC_BIT_FIFO_TR   3
`define VSOC_BIT_WIDE_FMT  4

// Reset values.
`define VSOC_RST_BYTE      8'h00
`define VSOC_RST_V_LOW     8'h80
`define VSOC_RST_V_HIGH    8'h7F
`define VSOC_RST_U_LOW     8'h80
`define VSOC_RST_U_HIGH    8'h7F

// AXI responses.
`define VSOC_RESP_OKAY     2'h0
`define VSOC_RESP_SLVERR   2'h2

`endif

// ===== rtl/vsoc_chroma_limit.v
`timescale 1ns/1ps

module vsoc_chroma_limit (
    input  wire [7:0] sample_in,
    input  wire       in_signed_in,
    input  wire       out_signed_in,
    input  wire [7:0] lower_in,
    input  wire [7:0] upper_in,
    output wire [7:0] sample_out
);

    // Bring a sample into two's complement form.
    function [7:0] vsoc_to_twos;
        input [7:0] value;
        input       is_signed;
        begin
            vsoc_to_twos = is_signed ? value : (value ^ 8'h80);
        end
    endfunction

    wire [7:0] twos_value;
    wire [7:0] limited;

    // Offset binary input is re-centred before comparison.
    assign twos_value = vsoc_to_twos(sample_in, in_signed_in);

    // Samples outside the window take the nearest bound.
    assign limited = ($signed(twos_value) < $signed(lower_in)) ? lower_in :
                     ($signed(twos_value) > $signed(upper_in)) ? upper_in : twos_value;

    // Output in two's complement or straight binary.
    assign sample_out = vsoc_to_twos(limited, out_signed_in);

endmodule // vsoc_chroma_limit

// ===== rtl/vsoc_top.v
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "vsoc_defs.vh"

module vsoc_top (
    input  wire        sys_clk_in,
    input  wire        rst_b_in,
    // AXI4-Lite slave.
    input  wire [7:0]  s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output wire        s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output wire        s_axi_wready_out,
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    input  wire [7:0]  s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output wire        s_axi_arready_out,
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    // Video side.
    input  wire        field_start_in,
    input  wire        line_start_in,
    input  wire        scale_active_in,
    input  wire        field_odd_in,
    input  wire        line_valid_in,
    input  wire        pixel_valid_in,
    input  wire        pixel_in_valid_in,
    input  wire [7:0]  y_in,
    input  wire [7:0]  u_in,
    input  wire [7:0]  v_in,
    input  wire        grey_select_in,
    input  wire [2:0]  format_select_in,
    input  wire        mem_ready_in,
    output reg  [7:0]  y_out,
    output reg  [7:0]  u_out,
    output reg  [7:0]  v_out,
    output wire        pixel_out_valid_out,
    output reg         bypass_active_out,
    output reg         field_flag_out,
    output reg         line_qualifier_out,
    output reg         pixel_out_bit1_out,
    output reg         pixel_out_bit0_out,
    output reg  [2:0]  format_code_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset synchroniser.
    reg rst_meta_reg;
    reg rst_sync_b_reg;

    // The first stage feeds only the second.
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_reg   <= 1'b0;
            rst_sync_b_reg <= 1'b0;
        end else begin
            rst_meta_reg   <= 1'b1;
            rst_sync_b_reg <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    reg  [7:0] byp_low_reg;
    reg  [2:0] byp_high_reg;
    reg  [7:0] v_lower_bound_reg;
    reg  [7:0] v_upper_bound_reg;
    reg  [7:0] u_lower_bound_reg;
    reg  [7:0] u_upper_bound_reg;
    reg  [4:0] out_ctrl_reg;
    reg  [8:0] bypass_first_line_reg;

    // Lines seen in this field.
    reg  [8:0] line_cnt_reg;

    // Decoded fields.
    wire [8:0] bypass_line_count;
    wire       input_chroma_signed;
    wire       field_flag_invert;
    wire       output_number_format;
    wire       line_qual_polarity;
    wire       pixel_qual_polarity;
    wire       fifo_transparent;
    wire       wide_format_enable;

    assign bypass_line_count    = {byp_high_reg[`VSOC_BIT_COUNT8], byp_low_reg};

    // Single-bit flags.
    assign input_chroma_signed  = byp_high_reg[`VSOC_BIT_CHROMA_S];
    assign field_flag_invert    = byp_high_reg[`VSOC_BIT_FLD_INV];
    assign output_number_format = out_ctrl_reg[`VSOC_BIT_NUMFMT];
    assign line_qual_polarity   = out_ctrl_reg[`VSOC_BIT_LINE_POL];
    assign pixel_qual_polarity  = out_ctrl_reg[`VSOC_BIT_PIX_POL];
    assign fifo_transparent     = out_ctrl_reg[`VSOC_BIT_FIFO_TR];
    assign wide_format_enable   = out_ctrl_reg[`VSOC_BIT_WIDE_FMT];

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel.
    reg        aw_held_reg;
    reg [5:0]  aw_idx_reg;
    reg        w_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;

    // Held or live beat completes a write.
    wire       do_write;
    wire [5:0] wr_idx;
    wire [31:0] wr_data;
    wire        wr_lane0;

    assign s_axi_awready_out = !aw_held_reg && !s_axi_bvalid_out;
    assign s_axi_wready_out  = !w_held_reg && !s_axi_bvalid_out;

    assign wr_idx   = aw_held_reg ? aw_idx_reg : s_axi_awaddr_in[7:2];
    assign wr_data  = w_held_reg ? w_data_reg : s_axi_wdata_in;
    assign wr_lane0 = w_held_reg ? w_strb_reg[0] : s_axi_wstrb_in[0];

    assign do_write = (aw_held_reg || (s_axi_awvalid_in && s_axi_awready_out)) &&
                      (w_held_reg || (s_axi_wvalid_in && s_axi_wready_out));

    // Decodes whether an index maps to a register.
    function vsoc_mapped;
        input [5:0] idx;
        begin
            vsoc_mapped = ({2'h0, idx} >= `VSOC_IDX_BYP_LOW) && ({2'h0, idx} <= `VSOC_IDX_STATUS);
        end
    endfunction

    // Address and data are held until both have arrived; response follows.
    always @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            aw_held_reg      <= 1'b0;
            aw_idx_reg       <= 6'h00;
            w_held_reg       <= 1'b0;
            w_data_reg       <= 32'h00000000;
            w_strb_reg       <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= `VSOC_RESP_OKAY;
        end else begin
            if (do_write) begin
                aw_held_reg      <= 1'b0;
                w_held_reg       <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= vsoc_mapped(wr_idx) ? `VSOC_RESP_OKAY : `VSOC_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid_in && s_axi_awready_out) begin
                    aw_held_reg <= 1'b1;
                    aw_idx_reg  <= s_axi_awaddr_in[7:2];
                end

                if (s_axi_wvalid_in && s_axi_wready_out) begin
                    w_held_reg <= 1'b1;
                    w_data_reg <= s_axi_wdata_in;
                    w_strb_reg <= s_axi_wstrb_in;
                end

                if (s_axi_bvalid_out && s_axi_bready_in) begin
                    s_axi_bvalid_out <= 1'b0;
                end
            end
        end
    end

    // Register storage; writes need byte lane 0, which carries all data except bit 8 of bypass_first_line_reg.
    always @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            byp_low_reg           <= `VSOC_RST_BYTE;
            byp_high_reg          <= 3'h0;
            v_lower_bound_reg     <= `VSOC_RST_V_LOW;
            v_upper_bound_reg     <= `VSOC_RST_V_HIGH;
            u_lower_bound_reg     <= `VSOC_RST_U_LOW;
            u_upper_bound_reg     <= `VSOC_RST_U_HIGH;
            out_ctrl_reg          <= 5'h00;
            bypass_first_line_reg <= 9'h000;
        end else if (do_write && wr_lane0) begin
            case ({2'h0, wr_idx})
                `VSOC_IDX_BYP_LOW:   byp_low_reg <= wr_data[7:0];
                `VSOC_IDX_BYP_HIGH:  byp_high_reg <= wr_data[2:0];
                `VSOC_IDX_V_LOW:     v_lower_bound_reg <= wr_data[7:0];
                `VSOC_IDX_V_HIGH:    v_upper_bound_reg <= wr_data[7:0];
                `VSOC_IDX_U_LOW:     u_lower_bound_reg <= wr_data[7:0];
                `VSOC_IDX_U_HIGH:    u_upper_bound_reg <= wr_data[7:0];
                `VSOC_IDX_OUT_CTRL:  out_ctrl_reg <= wr_data[4:0];
                `VSOC_IDX_BYP_FIRST: bypass_first_line_reg <= wr_data[8:0];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.
    reg [31:0] rd_word;
    wire [5:0] rd_idx;

    // One read at a time.
    assign s_axi_arready_out = !s_axi_rvalid_out;
    assign rd_idx = s_axi_araddr_in[7:2];

    // Read multiplexer; unused upper bits read as zero.
    always @* begin
        case ({2'h0, rd_idx})
            `VSOC_IDX_BYP_LOW:   rd_word = {24'h000000, byp_low_reg};
            `VSOC_IDX_BYP_HIGH:  rd_word = {29'h00000000, byp_high_reg};
            `VSOC_IDX_V_LOW:     rd_word = {24'h000000, v_lower_bound_reg};
            `VSOC_IDX_V_HIGH:    rd_word = {24'h000000, v_upper_bound_reg};
            `VSOC_IDX_U_LOW:     rd_word = {24'h000000, u_lower_bound_reg};
            `VSOC_IDX_U_HIGH:    rd_word = {24'h000000, u_upper_bound_reg};
            `VSOC_IDX_OUT_CTRL:  rd_word = {27'h0000000, out_ctrl_reg};
            `VSOC_IDX_BYP_FIRST: rd_word = {23'h000000, bypass_first_line_reg};
            `VSOC_IDX_STATUS:    rd_word = {21'h000000, field_flag_out, bypass_active_out, line_cnt_reg};
            default:             rd_word = 32'h00000000;
        endcase
    end

    // Read data is captured on the same edge that the address is taken.
    always @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= 32'h00000000;
            s_axi_rresp_out  <= `VSOC_RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out  <= rd_word;
            s_axi_rresp_out  <= vsoc_mapped(rd_idx) ? `VSOC_RESP_OKAY : `VSOC_RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line counter and bypass region.
    // One past the last bypassed line.
    wire [9:0] byp_end;
    wire       in_bypass;

    assign byp_end   = {1'b0, bypass_first_line_reg} + {1'b0, bypass_line_count};
    assign in_bypass = ({1'b0, line_cnt_reg} >= {1'b0, bypass_first_line_reg}) &&
                       ({1'b0, line_cnt_reg} < byp_end);

    // Counts lines in the field; scaling overrides the bypass window.
    always @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            line_cnt_reg      <= 9'h000;
            bypass_active_out <= 1'b0;
            field_flag_out    <= 1'b0;
        end else begin
            if (field_start_in) begin
                line_cnt_reg <= 9'h000;
            end else if (line_start_in && line_cnt_reg != 9'h1FF) begin
                line_cnt_reg <= line_cnt_reg + 9'h001;
            end

            bypass_active_out <= in_bypass && !scale_active_in;
            field_flag_out    <= field_odd_in ^ field_flag_invert;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pixel path.
    wire [7:0] u_limited;
    wire [7:0] v_limited;
    wire       line_q;
    wire       pix_q;

    // Pixel waiting for the memory.
    reg        hold_valid_reg;

    // U chroma path.
    vsoc_chroma_limit u_limit (
        .sample_in     (u_in),
        .in_signed_in  (input_chroma_signed),
        .out_signed_in (output_number_format),
        .lower_in      (u_lower_bound_reg),
        .upper_in      (u_upper_bound_reg),
        .sample_out    (u_limited)
    );

    // V chroma path.
    vsoc_chroma_limit v_limit (
        .sample_in     (v_in),
        .in_signed_in  (input_chroma_signed),
        .out_signed_in (output_number_format),
        .lower_in      (v_lower_bound_reg),
        .upper_in      (v_upper_bound_reg),
        .sample_out    (v_limited)
    );

    // Qualifiers follow their polarity bits.
    assign line_q = line_valid_in ^ !line_qual_polarity;
    assign pix_q  = pixel_valid_in ^ !pixel_qual_polarity;

    // Transparent mode shifts every cycle; memory mode waits for acceptance.
    assign pixel_out_valid_out = fifo_transparent ? pixel_in_valid_in : hold_valid_reg;

    // Output stage registers, loaded as memory protocol or shift register.
    always @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            y_out              <= 8'h00;
            u_out              <= 8'h00;
            v_out              <= 8'h00;
            hold_valid_reg     <= 1'b0;
            line_qualifier_out <= 1'b1;
            pixel_out_bit1_out <= 1'b1;
            pixel_out_bit0_out <= 1'b1;
            format_code_out    <= 3'h0;
        end else begin
            line_qualifier_out <= line_q;
            pixel_out_bit1_out <= line_q;
            pixel_out_bit0_out <= pix_q;
            format_code_out    <= wide_format_enable ? format_select_in : {1'b0, format_select_in[1:0]};

            // Memory mode holds until taken.
            if (fifo_transparent || !hold_valid_reg || mem_ready_in) begin
                hold_valid_reg <= pixel_in_valid_in;
                if (pixel_in_valid_in) begin
                    y_out <= (grey_select_in && !output_number_format) ? ~y_in : y_in;
                    u_out <= u_limited;
                    v_out <= v_limited;
                end
            end
        end
    end

endmodule // vsoc_top

// ===== verification/vsoc_mem_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Video memory write side that takes the held output pixel.
module vsoc_mem_model (
    input  wire       clk_in,
    input  wire       rst_b_in,
    input  wire       valid_in,
    input  wire       stall_in,
    input  wire       slow_in,
    output wire       ready_out,
    output reg  [7:0] taken_out
);
    reg phase_reg;
    // Ready unless stalled, and only every other cycle in slow mode.
    assign ready_out = !stall_in && (!slow_in || phase_reg);
    // Toggle the slow phase and count the pixels the memory has taken.
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phase_reg <= 1'h0;
            taken_out <= 8'h00;
        end else begin
            phase_reg <= !phase_reg;
            if (valid_in && ready_out) taken_out <= taken_out + 8'h01;
        end
    end
endmodule // vsoc_mem_model

// ===== verification/vsoc_checker.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Port-level checks; field flag and qualifier outputs are compared against their own history, the format code against its select.
module vsoc_checker (
    input wire        sys_clk_in,
    input wire        rst_b_in,
    input wire        s_axi_awvalid_in,
    input wire        s_axi_awready_out,
    input wire        s_axi_wvalid_in,
    input wire        s_axi_wready_out,
    input wire        s_axi_bvalid_out,
    input wire        s_axi_arvalid_in,
    input wire        s_axi_arready_out,
    input wire        s_axi_rvalid_out,
    input wire        s_axi_rready_in,
    input wire [31:0] s_axi_rdata_out,
    input wire        field_odd_in,
    input wire        field_flag_out,
    input wire        line_valid_in,
    input wire        line_qualifier_out,
    input wire        pixel_out_bit1_out,
    input wire        pixel_valid_in,
    input wire        pixel_out_bit0_out,
    input wire        scale_active_in,
    input wire        bypass_active_out,
    input wire [2:0]  format_select_in,
    input wire [2:0]  format_code_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    reg  [2:0] live_cnt;
    reg  [1:0] quiet_cnt;
    wire       live  = live_cnt > 3'h3;
    wire       quiet = live && (quiet_cnt == 2'h3);
    // Count edges since reset and since the last write beat, so settings are known stable.
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            live_cnt  <= 3'h0;
            quiet_cnt <= 2'h0;
        end else begin
            if (!live) live_cnt <= live_cnt + 3'h1;
            if ((s_axi_awvalid_in && s_axi_awready_out) || (s_axi_wvalid_in && s_axi_wready_out)) quiet_cnt <= 2'h0;
            else if (quiet_cnt != 2'h3) quiet_cnt <= quiet_cnt + 2'h1;
        end
    end
    property p_field_inv;
        quiet |-> ((field_flag_out ^ $past(field_odd_in)) == ($past(field_flag_out) ^ $past(field_odd_in, 2)));
    endproperty
    a_field_inv: assert property (p_field_inv) else $error("field flag inversion drifted");
    property p_line_pins;
        line_qualifier_out == pixel_out_bit1_out;
    endproperty
    a_line_pins: assert property (p_line_pins) else $error("line qualifier pins differ");
    property p_line_pol;
        quiet |-> ((line_qualifier_out ^ $past(line_valid_in)) == ($past(line_qualifier_out) ^ $past(line_valid_in, 2)));
    endproperty
    a_line_pol: assert property (p_line_pol) else $error("line qualifier polarity drifted");
    property p_pix_pol;
        quiet |-> ((pixel_out_bit0_out ^ $past(pixel_valid_in)) == ($past(pixel_out_bit0_out) ^ $past(pixel_valid_in, 2)));
    endproperty
    a_pix_pol: assert property (p_pix_pol) else $error("pixel qualifier polarity drifted");
    property p_format;
        live |-> (format_code_out == $past(format_select_in)) || (format_code_out == ($past(format_select_in) & 3'h3));
    endproperty
    a_format: assert property (p_format) else $error("format code not taken from select");
    property p_scale_wins;
        live && $past(scale_active_in) |-> !bypass_active_out;
    endproperty
    a_scale_wins: assert property (p_scale_wins) else $error("bypass while scaling");
    property p_bresp;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out |=> s_axi_bvalid_out;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response late");
    property p_bblock;
        s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
    endproperty
    a_bblock: assert property (p_bblock) else $error("write taken while response pending");
    property p_rresp;
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
    endproperty
    a_rresp: assert property (p_rresp) else $error("read response late");
    property p_rhold;
        s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
endmodule // vsoc_checker
bind vsoc_top vsoc_checker vsoc_checker_inst (.sys_clk_in, .rst_b_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .field_odd_in, .field_flag_out, .line_valid_in,
    .line_qualifier_out, .pixel_out_bit1_out, .pixel_valid_in, .pixel_out_bit0_out, .scale_active_in,
    .bypass_active_out, .format_select_in, .format_code_out);

// ===== verification/vsoc_tb_top.sv
`timescale 1ns/1ps
`include "vsoc_defs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s expected %h seen %h", n, e, g); end end
////////////////////////////////////////////////////////////////
// Register and pixel-path bench for the output configuration block.
module vsoc_tb_top;
    logic        sys_clk_in, rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
    logic        s_axi_rready_in, field_start_in, line_start_in, scale_active_in, field_odd_in, line_valid_in;
    logic        pixel_valid_in, pixel_in_valid_in, grey_select_in, mem_ready_in, stall, slow;
    logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic        pixel_out_valid_out, bypass_active_out, field_flag_out, line_qualifier_out;
    logic        pixel_out_bit1_out, pixel_out_bit0_out;
    logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in, y_in, u_in, v_in, y_out, u_out, v_out, taken, t0;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    logic [2:0]  format_select_in, format_code_out;
    logic [7:0]  rst_vals [7] = '{8'h00, 8'h00, 8'h80, 8'h7F, 8'h80, 8'h7F, 8'h00};
    logic [7:0]  masks [7]    = '{8'hFF, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F};
    int          num_errors = 0;
    int          samples_checked = 0;
    vsoc_top vsoc_top_inst (.*);
    vsoc_mem_model vsoc_mem_model_inst (.clk_in(sys_clk_in), .rst_b_in(rst_b_in), .valid_in(pixel_out_valid_out),
        .stall_in(stall), .slow_in(slow), .ready_out(mem_ready_in), .taken_out(taken));
    // Free-running system clock.
    initial begin
        sys_clk_in = 1'h0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    // Prints the verdict and ends the run.
    task automatic wrap_up;
        if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    // Register write; each channel is released once taken.
    task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s = 4'hF, input [1:0] er = `VSOC_RESP_OKAY);
        logic aw_ok, w_ok, b_ok;
        logic [1:0] rsp;
        @(posedge sys_clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_wstrb_in <= s;
        s_axi_awvalid_in <= 1'h1;
        s_axi_wvalid_in <= 1'h1;
        s_axi_bready_in <= 1'h1;
        do begin
            @(negedge sys_clk_in);
            aw_ok = s_axi_awvalid_in && s_axi_awready_out;
            w_ok = s_axi_wvalid_in && s_axi_wready_out;
            b_ok = s_axi_bvalid_out;
            rsp = s_axi_bresp_out;
            @(posedge sys_clk_in);
            if (aw_ok) s_axi_awvalid_in <= 1'h0;
            if (w_ok) s_axi_wvalid_in <= 1'h0;
        end while (!b_ok);
        s_axi_bready_in <= 1'h0;
        `CHK("write response", er, rsp)
    endtask
    // Register read; rready is raised late.
    task automatic rd(input [7:0] a, input [31:0] ed, input [1:0] er = `VSOC_RESP_OKAY);
        logic ar_ok;
        @(posedge sys_clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'h1;
        do begin
            @(negedge sys_clk_in);
            ar_ok = s_axi_arready_out;
            @(posedge sys_clk_in);
        end while (!ar_ok);
        s_axi_arvalid_in <= 1'h0;
        do @(negedge sys_clk_in); while (!s_axi_rvalid_out);
        `CHK("read data", ed, s_axi_rdata_out)
        `CHK("read response", er, s_axi_rresp_out)
        @(posedge sys_clk_in);
        s_axi_rready_in <= 1'h1;
        @(posedge sys_clk_in);
        s_axi_rready_in <= 1'h0;
    endtask
    task automatic pix(input [7:0] y, u, v);
        @(posedge sys_clk_in);
        {y_in, u_in, v_in} <= {y, u, v};
        pixel_in_valid_in <= 1'h1;
        @(posedge sys_clk_in);
        pixel_in_valid_in <= 1'h0;
        #1;
    endtask
    // Pulses line starts, then looks at the bypass flag.
    task automatic lines(input int n, input logic e);
        repeat (n) begin
            @(posedge sys_clk_in);
            line_start_in <= 1'h1;
            @(posedge sys_clk_in);
            line_start_in <= 1'h0;
        end
        step(2);
        `CHK("bypass", e, bypass_active_out)
    endtask
    // Main sequence.
    initial begin
        {rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
        {field_start_in, line_start_in, scale_active_in, field_odd_in, line_valid_in, pixel_valid_in} = '0;
        {pixel_in_valid_in, grey_select_in, stall, slow} = '0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in, y_in, u_in, v_in, format_select_in} = '0;
        repeat (4) @(posedge sys_clk_in);
        rst_b_in <= 1'h1;
        repeat (3) @(posedge sys_clk_in);
        for (int i = 0; i < 7; i++) rd(8'h28 + 8'(4 * i), {24'h0, rst_vals[i]});
        for (int i = 0; i < 7; i++) begin
            wr(8'h28 + 8'(4 * i), 32'hFFFF_FFFF);
            rd(8'h28 + 8'(4 * i), {24'h0, masks[i]});
        end
        wr(8'h30, 32'h11, 4'h0);
        rd(8'h30, 32'hFF);
        wr(8'h80, 32'h1, 4'hF, `VSOC_RESP_SLVERR);
        rd(8'h80, 32'h0, `VSOC_RESP_SLVERR);
        wr(8'h44, 32'h2);
        rd(8'h44, 32'h2);
        wr(8'h28, 32'h1);
        wr(8'h2C, 32'h1);
        @(posedge sys_clk_in);
        field_start_in <= 1'h1;
        @(posedge sys_clk_in);
        field_start_in <= 1'h0;
        lines(1, 1'h0);
        lines(1, 1'h1);
        lines(256, 1'h1);
        @(posedge sys_clk_in);
        scale_active_in <= 1'h1;
        step(2);
        `CHK("scaling over bypass", 1'h0, bypass_active_out)
        @(posedge sys_clk_in);
        scale_active_in <= 1'h0;
        lines(1, 1'h0);
        rd(8'h48, 32'h103);
        @(posedge sys_clk_in);
        field_odd_in <= 1'h1;
        wr(8'h2C, 32'h5);
        step(2);
        `CHK("field flag", 1'h0, field_flag_out)
        wr(8'h2C, 32'h1);
        step(2);
        `CHK("field flag", 1'h1, field_flag_out)
        @(posedge sys_clk_in);
        {line_valid_in, pixel_valid_in, format_select_in} <= {2'h3, 3'h6};
        wr(8'h40, 32'h0);
        step(2);
        `CHK("qualifiers", 6'h02, {line_qualifier_out, pixel_out_bit1_out, pixel_out_bit0_out, format_code_out})
        wr(8'h40, 32'h16);
        step(2);
        `CHK("qualifiers", 6'h3E, {line_qualifier_out, pixel_out_bit1_out, pixel_out_bit0_out, format_code_out})
        wr(8'h2C, 32'h3);
        wr(8'h40, 32'h1);
        wr(8'h30, 32'hF6);
        wr(8'h34, 32'h14);
        wr(8'h38, 32'h00);
        wr(8'h3C, 32'h05);
        pix(8'h12, 8'h7F, 8'h80);
        `CHK("pixel", 24'h1205F6, {y_out, u_out, v_out})
        pix(8'h12, 8'h81, 8'h10);
        `CHK("pixel", 24'h120010, {y_out, u_out, v_out})
        wr(8'h2C, 32'h1);
        wr(8'h40, 32'h0);
        @(posedge sys_clk_in);
        grey_select_in <= 1'h1;
        pix(8'h12, 8'h80, 8'h00);
        `CHK("pixel", 24'hED8076, {y_out, u_out, v_out})
        wr(8'h40, 32'h1);
        pix(8'h12, 8'h00, 8'h00);
        `CHK("pixel", 24'h1200F6, {y_out, u_out, v_out})
        stall = 1'h1;
        t0 = taken;
        wr(8'h40, 32'h0);
        pix(8'h01, 8'h00, 8'h00);
        pix(8'h02, 8'h00, 8'h00);
        `CHK("held pixel", 9'h112, {pixel_out_valid_out, y_out})
        stall = 1'h0;
        slow = 1'h1;
        step(3);
        `CHK("memory take", {1'h0, 8'(t0 + 8'h01)}, {pixel_out_valid_out, taken})
        stall = 1'h1;
        wr(8'h40, 32'h8);
        @(posedge sys_clk_in);
        y_in <= 8'h04;
        pixel_in_valid_in <= 1'h1;
        #1;
        `CHK("shift valid", 1'h1, pixel_out_valid_out)
        @(posedge sys_clk_in);
        pixel_in_valid_in <= 1'h0;
        #1;
        `CHK("shift pixel", 9'h0FB, {pixel_out_valid_out, y_out})
        wrap_up;
    end
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        num_errors++;
        wrap_up;
    end
endmodule // vsoc_tb_top
